// file: core/drive_ctrl_pkg.sv
// constants, register map and types of the drive start/stop sequencer
// assumes a 100 MHz core clock and an Avalon-MM register bus with byte
// addresses; settings are written by software before a run is commanded
package drive_ctrl_pkg;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_HZ = 100_000_000;
    localparam int TICK_MS = 100; // unit of hold and braking times
    localparam int TICK_CYCLES_DEF = TICK_MS * (CLK_HZ / 1000);
    localparam int RAMP_US = 1000; // time per 0.1 Hz frequency step
    localparam int RAMP_CYCLES_DEF = RAMP_US * (CLK_HZ / 1_000_000);
    localparam int SLOW_RISE_US = 10; // time per 1 % in slow braking
    localparam int SLOW_RISE_CYCLES = SLOW_RISE_US * (CLK_HZ / 1_000_000);

    // ----------------------------------------------------------------
    // limits (frequency 0.1 Hz, carrier 0.01 kHz, current 1 %)
    // ----------------------------------------------------------------
    localparam logic [7:0] BRAKE_LEVEL_MAX = 8'h64;
    localparam logic [15:0] CARRIER_MIN = 16'h004b;
    localparam logic [15:0] CARRIER_MAX = 16'h05dc;
    localparam logic [15:0] TONE_LIMIT = 16'h02bc;
    localparam int ADC_FS_SHIFT = 11; // 12-bit adc, 2047 = 10 V
    localparam int MON_GAIN_SHIFT = 8; // monitor gain 16'h0100 = 1.0

    // ----------------------------------------------------------------
    // register map (byte offsets)
    // ----------------------------------------------------------------
    localparam logic [5:0] ADDR_CTRL = 6'h00;
    localparam logic [5:0] ADDR_START = 6'h04;
    localparam logic [5:0] ADDR_STOP = 6'h08;
    localparam logic [5:0] ADDR_BRAKE = 6'h0c;
    localparam logic [5:0] ADDR_CARRIER = 6'h10;
    localparam logic [5:0] ADDR_REF = 6'h14;
    localparam logic [5:0] ADDR_REF2 = 6'h18;
    localparam logic [5:0] ADDR_STATUS = 6'h1c;
    localparam logic [5:0] ADDR_STATUS2 = 6'h20;

    // control register fields
    localparam int CTRL_RUN = 0;
    localparam int CTRL_RESP = 1;
    localparam int CTRL_AUTO_CARR = 2;
    localparam int CTRL_POLARITY = 3;
    localparam int CTRL_FORM_LO = 4;
    localparam logic [1:0] MON_FORM_DC = 2'h0;
    localparam logic [1:0] MON_FORM_PULSE = 2'h2;

    // reset values
    localparam logic [31:0] CTRL_RST = 32'h0000_000c;
    localparam logic [31:0] START_RST = 32'h0000_0005;
    localparam logic [31:0] STOP_RST = 32'h0000_0002;
    localparam logic [31:0] BRAKE_RST = 32'h0000_0000;
    localparam logic [31:0] CARRIER_RST = 32'h0000_0190;
    localparam logic [31:0] REF_RST = 32'h0000_0258;
    localparam logic [31:0] REF2_RST = 32'h0100_0000;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_STOPPED = 3'b000,
        ST_START_HOLD = 3'b001,
        ST_RUN = 3'b010,
        ST_DECEL = 3'b011,
        ST_STOP_HOLD = 3'b100,
        ST_BRAKE = 3'b101
    } drive_state_type;

    typedef struct packed {
        logic [15:0] hold;
        logic [15:0] freq;
    } freq_hold_type;

    typedef struct packed {
        logic [7:0] duration;
        logic [7:0] level;
        logic [15:0] freq;
    } brake_cfg_type;

endpackage

// file: core/drive_start_stop.sv
// start/stop frequency sequencer with dc injection braking, carrier and
// tone limits, reference scaling and monitor output of a motor drive
// assumes pins ref_adc_in, ext_brake_enable and overheat_in are async to
// clk; software programs settings over Avalon-MM before commanding run
//
// Contract
// - on a stop by run removal or reference below stop frequency, dc is injected at the set level for the set time once output reaches the braking start frequency.
// - a braking duration of zero disables timed dc braking.
// - braking level is a percentage of rated current, 100 is rated, steps of 1.
// - response select 0 ramps braking current slowly, 1 applies it at once.
// - while the external brake enable is high, braking stays on regardless of duration.
// - raising the external brake enable while stopped starts braking.
// - the first output frequency at startup equals the start frequency.
// - during a stop the output is cut once frequency reaches the stop frequency.
// - the output is held at the start frequency for the start hold time.
// - the output is held at the stop frequency for the stop hold time before cut-off.
// - with start below stop frequency, no output until the reference exceeds stop.
// - the carrier setting is accepted within 0.75 to 15 kHz.
// - on overheat the carrier drops automatically unless that is disabled.
// - the motor tone applies only when the carrier is 7 kHz or lower.
// - polarity select 0 makes the reference input bipolar, -10 V to +10 V.
// - bipolar input with zero bias maps symmetric about zero frequency.
// - the monitor is a scaled dc level or a 50 % duty pulse train.
`timescale 1ns/1ns
module drive_start_stop
    import drive_ctrl_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYCLES_DEF,
    parameter int RAMP_CYCLES = RAMP_CYCLES_DEF
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // avalon-mm slave
    input wire logic [5:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    // pins
    input wire logic signed [11:0] ref_adc_in,
    input wire logic ext_brake_enable,
    input wire logic overheat_in,
    // power stage
    output logic [15:0] out_freq,
    output logic out_dir,
    output logic out_enable,
    output logic brake_active,
    output logic [7:0] brake_current,
    output logic [15:0] carrier_eff,
    output logic [7:0] tone_level,
    // monitor
    output logic [15:0] monitor_dc,
    output logic monitor_pulse
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] be_merge(input logic [31:0] old,
            input logic [31:0] nw, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [15:0] sat16(input logic signed [33:0] v);
        if (v < 0) begin
            return 16'h0000;
        end else if (v > 34'sh0_0000_ffff) begin
            return 16'hffff;
        end
        return v[15:0];
    endfunction

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [11:0] adc_meta_ff, adc_ff;
    logic ext_meta_ff, ext_ff, heat_meta_ff, heat_ff;

    // the adc is assumed to hold its code over several clocks
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            adc_meta_ff <= 12'h000;
            adc_ff <= 12'h000;
            ext_meta_ff <= 1'b0;
            ext_ff <= 1'b0;
            heat_meta_ff <= 1'b0;
            heat_ff <= 1'b0;
        end else begin
            adc_meta_ff <= ref_adc_in;
            adc_ff <= adc_meta_ff;
            ext_meta_ff <= ext_brake_enable;
            ext_ff <= ext_meta_ff;
            heat_meta_ff <= overheat_in;
            heat_ff <= heat_meta_ff;
        end
    end

    // ----------------------------------------------------------------
    // register bus
    // ----------------------------------------------------------------
    logic [31:0] ctrl_ff, carrier_ff, ref_ff, ref2_ff;
    freq_hold_type start_ff, stop_ff;
    brake_cfg_type brake_ff;
    logic waitrequest_ff;
    logic [31:0] readdata_ff, nxt_readdata;
    logic bus_req, wr_take;
    drive_state_type state_ff, nxt_state;
    logic [15:0] freq_ff, carrier_eff_ff;
    logic [7:0] brake_cur_ff;
    logic dir_ff, enable_ff, brake_act_ff;

    assign bus_req = read | write;
    assign wr_take = write & ~waitrequest_ff;

    // one wait cycle per access: low for one cycle, then high again
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            waitrequest_ff <= 1'b1;
        end else begin
            waitrequest_ff <= ~(bus_req & waitrequest_ff);
        end
    end

    // writes land at the edge where waitrequest is seen low
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl_ff <= CTRL_RST;
            start_ff <= START_RST;
            stop_ff <= STOP_RST;
            brake_ff <= BRAKE_RST;
            carrier_ff <= CARRIER_RST;
            ref_ff <= REF_RST;
            ref2_ff <= REF2_RST;
        end else if (wr_take) begin
            case (address)
                ADDR_CTRL: ctrl_ff <= be_merge(ctrl_ff, writedata, byteenable);
                ADDR_START: start_ff <= be_merge(start_ff, writedata,
                    byteenable);
                ADDR_STOP: stop_ff <= be_merge(stop_ff, writedata, byteenable);
                ADDR_BRAKE: brake_ff <= be_merge(brake_ff, writedata,
                    byteenable);
                ADDR_CARRIER: carrier_ff <= be_merge(carrier_ff, writedata,
                    byteenable);
                ADDR_REF: ref_ff <= be_merge(ref_ff, writedata, byteenable);
                ADDR_REF2: ref2_ff <= be_merge(ref2_ff, writedata, byteenable);
                default: ;
            endcase
        end
    end

    // read mux; unmapped addresses read as zero
    always_comb begin
        nxt_readdata = 32'h0000_0000;
        case (address)
            ADDR_CTRL: nxt_readdata = ctrl_ff;
            ADDR_START: nxt_readdata = start_ff;
            ADDR_STOP: nxt_readdata = stop_ff;
            ADDR_BRAKE: nxt_readdata = brake_ff;
            ADDR_CARRIER: nxt_readdata = carrier_ff;
            ADDR_REF: nxt_readdata = ref_ff;
            ADDR_REF2: nxt_readdata = ref2_ff;
            ADDR_STATUS: nxt_readdata = {10'h000, dir_ff, enable_ff,
                brake_act_ff, state_ff, freq_ff};
            ADDR_STATUS2: nxt_readdata = {8'h00, brake_cur_ff,
                carrier_eff_ff};
            default: nxt_readdata = 32'h0000_0000;
        endcase
    end

    // data is loaded as waitrequest falls so it stands at the take edge
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            readdata_ff <= 32'h0000_0000;
        end else if (read & waitrequest_ff) begin
            readdata_ff <= nxt_readdata;
        end
    end

    // ----------------------------------------------------------------
    // reference scaling
    // ----------------------------------------------------------------
    logic signed [33:0] scaled, biased;
    logic ref_neg;
    logic [15:0] ref_mag;

    // bias base point only clips in unipolar mode; bipolar keeps sign
    always_comb begin
        scaled = (34'(signed'(adc_ff)) * signed'(34'(ref_ff[15:0])))
            >>> ADC_FS_SHIFT;
        biased = scaled + 34'(signed'(ref_ff[31:16]));
        ref_neg = 1'b0;
        if (ctrl_ff[CTRL_POLARITY]) begin
            if (adc_ff[11] || (12'(adc_ff) < ref2_ff[11:0])) begin
                biased = 34'(signed'(ref_ff[31:16]));
            end
            ref_mag = sat16(biased);
        end else begin
            ref_neg = biased < 0;
            ref_mag = sat16(ref_neg ? -biased : biased);
        end
    end

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    logic [31:0] tick_cnt_ff, ramp_cnt_ff;
    logic [15:0] timer_ff;
    logic [15:0] slow_cnt_ff;
    logic tick, ramp_tick, run, stop_req, brk_en, start_ok, new_state;
    logic [7:0] level;

    assign run = ctrl_ff[CTRL_RUN];
    assign brk_en = brake_ff.duration != 8'h00;
    assign stop_req = ~run | (ref_mag < stop_ff.freq);
    assign start_ok = (start_ff.freq < stop_ff.freq) ?
        (ref_mag > stop_ff.freq) :
        (ref_mag >= start_ff.freq && ref_mag != 16'h0000);
    assign new_state = nxt_state != state_ff;
    assign tick = tick_cnt_ff == 32'(TICK_CYCLES - 1);
    assign ramp_tick = ramp_cnt_ff == 32'(RAMP_CYCLES - 1);
    assign level = (brake_ff.level > BRAKE_LEVEL_MAX) ?
        BRAKE_LEVEL_MAX : brake_ff.level;

    // next state
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_STOPPED: begin
                if (ext_ff) begin
                    nxt_state = ST_BRAKE;
                end else if (run && start_ok) begin
                    nxt_state = ST_START_HOLD;
                end
            end
            ST_START_HOLD: begin
                if (!run) begin
                    nxt_state = ST_DECEL;
                end else if (timer_ff >= start_ff.hold) begin
                    nxt_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (stop_req) begin
                    nxt_state = ST_DECEL;
                end
            end
            ST_DECEL: begin
                if (!stop_req) begin
                    nxt_state = ST_RUN;
                end else if (brk_en && freq_ff <= brake_ff.freq) begin
                    nxt_state = ST_BRAKE;
                end else if (freq_ff <= stop_ff.freq) begin
                    nxt_state = ST_STOP_HOLD;
                end
            end
            ST_STOP_HOLD: begin
                if (timer_ff >= stop_ff.hold) begin
                    nxt_state = brk_en ? ST_BRAKE : ST_STOPPED;
                end
            end
            ST_BRAKE: begin
                // the external enable overrides the programmed duration
                if (!ext_ff && timer_ff >= 16'(brake_ff.duration)) begin
                    nxt_state = ST_STOPPED;
                end
            end
            default: nxt_state = ST_STOPPED;
        endcase
    end

    // state and per-state tick timer, restarted on each state change
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_ff <= ST_STOPPED;
            tick_cnt_ff <= 32'h0000_0000;
            timer_ff <= 16'h0000;
        end else begin
            state_ff <= nxt_state;
            if (new_state || tick) begin
                tick_cnt_ff <= 32'h0000_0000;
            end else begin
                tick_cnt_ff <= tick_cnt_ff + 32'h0000_0001;
            end
            if (new_state) begin
                timer_ff <= 16'h0000;
            end else if (tick && timer_ff != 16'hffff) begin
                timer_ff <= timer_ff + 16'h0001;
            end
        end
    end

    // output frequency: fixed-rate ramp of 0.1 Hz per ramp step
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ramp_cnt_ff <= 32'h0000_0000;
            freq_ff <= 16'h0000;
            dir_ff <= 1'b0;
        end else begin
            ramp_cnt_ff <= ramp_tick ? 32'h0000_0000 :
                ramp_cnt_ff + 32'h0000_0001;
            case (nxt_state)
                ST_START_HOLD: begin
                    if (state_ff == ST_STOPPED) begin
                        freq_ff <= start_ff.freq;
                        dir_ff <= ref_neg;
                    end
                end
                ST_RUN: begin
                    if (ramp_tick && freq_ff < ref_mag) begin
                        freq_ff <= freq_ff + 16'h0001;
                    end else if (ramp_tick && freq_ff > ref_mag) begin
                        freq_ff <= freq_ff - 16'h0001;
                    end
                end
                ST_DECEL: begin
                    if (ramp_tick && freq_ff != 16'h0000) begin
                        freq_ff <= freq_ff - 16'h0001;
                    end
                end
                ST_STOP_HOLD: freq_ff <= stop_ff.freq;
                default: freq_ff <= 16'h0000;
            endcase
        end
    end

    // output gating follows the next state so both change together
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            enable_ff <= 1'b0;
            brake_act_ff <= 1'b0;
        end else begin
            enable_ff <= nxt_state != ST_STOPPED &&
                nxt_state != ST_BRAKE;
            brake_act_ff <= nxt_state == ST_BRAKE;
        end
    end

    // braking current; slow rise trades early torque for no back-spin
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            brake_cur_ff <= 8'h00;
            slow_cnt_ff <= 16'h0000;
        end else if (nxt_state != ST_BRAKE) begin
            brake_cur_ff <= 8'h00;
            slow_cnt_ff <= 16'h0000;
        end else if (ctrl_ff[CTRL_RESP]) begin
            brake_cur_ff <= level;
        end else if (slow_cnt_ff == 16'(SLOW_RISE_CYCLES - 1)) begin
            slow_cnt_ff <= 16'h0000;
            if (brake_cur_ff < level) begin
                brake_cur_ff <= brake_cur_ff + 8'h01;
            end else begin
                brake_cur_ff <= level;
            end
        end else begin
            slow_cnt_ff <= slow_cnt_ff + 16'h0001;
        end
    end

    // ----------------------------------------------------------------
    // carrier and tone
    // ----------------------------------------------------------------
    logic [15:0] carr_set;
    logic [7:0] tone_ff;

    assign carr_set = (carrier_ff[15:0] < CARRIER_MIN) ? CARRIER_MIN :
        (carrier_ff[15:0] > CARRIER_MAX) ? CARRIER_MAX :
        carrier_ff[15:0];

    // dropping straight to the floor is crude but always clears the heat
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            carrier_eff_ff <= CARRIER_MIN;
            tone_ff <= 8'h00;
        end else begin
            carrier_eff_ff <= (heat_ff && ctrl_ff[CTRL_AUTO_CARR]) ?
                CARRIER_MIN : carr_set;
            tone_ff <= (carr_set <= TONE_LIMIT) ?
                carrier_ff[23:16] : 8'h00;
        end
    end

    // ----------------------------------------------------------------
    // monitor output
    // ----------------------------------------------------------------
    logic [15:0] mon_level, mon_dc_ff, mon_acc_ff;
    logic mon_pulse_ff;
    logic [1:0] form;
    logic [16:0] acc_sum;

    assign form = ctrl_ff[CTRL_FORM_LO +: 2];
    assign mon_level = sat16(34'((32'(freq_ff) * 32'(ref2_ff[31:16]))
        >> MON_GAIN_SHIFT));
    assign acc_sum = 17'(mon_acc_ff) + 17'(mon_level);

    // each accumulator wrap toggles the pin, so duty stays at 50 %
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mon_dc_ff <= 16'h0000;
            mon_acc_ff <= 16'h0000;
            mon_pulse_ff <= 1'b0;
        end else begin
            mon_dc_ff <= (form == MON_FORM_DC) ? mon_level : 16'h0000;
            if (form == MON_FORM_PULSE) begin
                mon_acc_ff <= acc_sum[15:0];
                mon_pulse_ff <= mon_pulse_ff ^ acc_sum[16];
            end else begin
                mon_acc_ff <= 16'h0000;
                mon_pulse_ff <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign readdata = readdata_ff;
    assign waitrequest = waitrequest_ff;
    assign out_freq = freq_ff;
    assign out_dir = dir_ff;
    assign out_enable = enable_ff;
    assign brake_active = brake_act_ff;
    assign brake_current = brake_cur_ff;
    assign carrier_eff = carrier_eff_ff;
    assign tone_level = tone_ff;
    assign monitor_dc = mon_dc_ff;
    assign monitor_pulse = mon_pulse_ff;

endmodule

// file: testbench/drive_start_stop_props.sv
// checker of the sequencer's port behaviour, bound to the design
// assumes only the top module's ports and its single clock
`timescale 1ns/1ns
module drive_start_stop_props (
    // clock, reset and bus
    input wire logic clk,
    input wire logic rst_n,
    input wire logic read,
    input wire logic write,
    input wire logic waitrequest,
    // pins and power stage
    input wire logic ext_brake_enable,
    input wire logic out_enable,
    input wire logic brake_active,
    input wire logic [15:0] out_freq,
    input wire logic [7:0] brake_current,
    input wire logic [15:0] carrier_eff,
    input wire logic [7:0] tone_level,
    input wire logic [15:0] monitor_dc,
    input wire logic monitor_pulse
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // enable held long enough to cross the two synchroniser flops
    sequence ext_idle_s;
        (ext_brake_enable && !out_enable)[*4];
    endsequence
    sequence ext_brake_s;
        (ext_brake_enable && brake_active)[*3];
    endsequence
    bus_answer_a: assert property ((read || write) && waitrequest
        |=> !waitrequest) else $error("bus answer missing");
    ext_start_a: assert property (
        ext_idle_s |-> ##[0:3] brake_active) else $error("no brake");
    ext_keep_a: assert property (
        ext_brake_s |=> brake_active) else $error("brake dropped");
    carrier_range_a: assert property (
        carrier_eff >= 16'h004b && carrier_eff <= 16'h05dc)
        else $error("carrier out of range");
    level_limit_a: assert property (
        brake_current <= 8'h64) else $error("brake over rated");
    tone_gate_a: assert property (
        carrier_eff > 16'h02bc |-> tone_level == 8'h00)
        else $error("tone above limit");
    monitor_form_a: assert property (
        $rose(monitor_pulse) |-> monitor_dc == 16'h0000)
        else $error("both monitor forms");
    start_freq_a: assert property (
        $rose(out_enable) |-> out_freq != 16'h0000)
        else $error("start at zero");
endmodule
bind drive_start_stop drive_start_stop_props props (.*);

// file: testbench/motor_model.sv
// motor and power stage as seen by the drive: heats under heavy load
// assumes the bench raises load_hi; no heat while the output is off
`timescale 1ns/1ns
module motor_model (
    // drive side
    input wire logic clk,
    input wire logic out_enable,
    input wire logic load_hi,
    // sensor back to the drive
    output logic overheat_in = 1'b0
);
    // one cycle late, like a slow thermal sensor
    always @(posedge clk) begin
        overheat_in <= out_enable && load_hi;
    end
endmodule

// file: testbench/drive_start_stop_tb.sv
// bench: avalon master, pin drivers and motor model around the design
// assumes the checker binds itself; ticks of 10, ramp steps of 4
`timescale 1ns/1ns
module drive_start_stop_tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic ext_brake_enable = 1'b0;
    logic load_hi = 1'b0;
    logic [5:0] address = 6'h00;
    logic [3:0] byteenable = 4'hf;
    logic [31:0] writedata = 32'h0;
    logic signed [11:0] ref_adc_in = 12'sh000;
    logic waitrequest, overheat_in, out_dir, out_enable, brake_active;
    logic monitor_pulse, hit;
    logic [15:0] out_freq, carrier_eff, monitor_dc, tgt, cs, ce;
    logic [7:0] brake_current, tone_level;
    logic [31:0] readdata, rd;
    logic [31:0] seed = 32'hf589;
    int fail_count = 0;
    int n_compared = 0;
    int n, k;
    // short ticks keep holds and braking to tens of cycles
    drive_start_stop #(.TICK_CYCLES(10), .RAMP_CYCLES(4)) dut (.*);
    motor_model motor (.*);
    initial begin
        forever #5 clk = ~clk;
    end
    // xorshift source of random settings
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic complete_run();
        if (fail_count == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] want);
        n_compared++;
        if (got !== want) begin
            fail_count++;
            $display("unexpected at %0t: saw %h want %h", $time, got, want);
        end
    endtask
    // one cycle of a bounded wait; running out ends the run as failed
    task automatic tick(input int c);
        @(posedge clk);
        if (c >= 3000) begin
            fail_count++;
            complete_run();
        end
    endtask
    // request held until waitrequest is sampled low, then released
    task automatic bus(input logic wr, input logic [5:0] a,
            input logic [31:0] d);
        int c;
        address <= a;
        write <= wr;
        read <= !wr;
        writedata <= d;
        tick(0);
        for (c = 1; waitrequest !== 1'b0; c++) tick(c);
        rd = readdata;
        write <= 1'b0;
        read <= 1'b0;
        @(posedge clk);
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        bus(1'b0, 6'h24, 32'h0);
        check(rd, 32'h0);
        bus(1'b1, 6'h14, 32'h0000_0800);
        bus(1'b1, 6'h04, 32'h0002_0014);
        bus(1'b1, 6'h08, 32'h0001_000a);
        bus(1'b1, 6'h0c, 32'h02c8_000f);
        bus(1'b0, 6'h0c, 32'h0);
        check(rd, 32'h02c8_000f);
        tgt = 16'd60 + 16'(rnd() & 32'h3f);
        ref_adc_in <= 12'(tgt);
        // run, overheat with and without reduction, timed braking
        bus(1'b1, 6'h00, 32'h0000_0007);
        for (n = 0; out_enable !== 1'b1; n++) tick(n);
        check(out_freq, 32'd20);
        repeat (15) @(posedge clk);
        check(out_freq, 32'd20);
        for (n = 0; out_freq !== tgt; n++) tick(n);
        check(out_dir, 32'h0);
        load_hi <= 1'b1;
        repeat (8) @(posedge clk);
        check(carrier_eff, 32'h004b);
        check(monitor_dc, tgt);
        bus(1'b1, 6'h00, 32'h0000_0003);
        repeat (8) @(posedge clk);
        check(carrier_eff, 32'h0190);
        load_hi <= 1'b0;
        bus(1'b1, 6'h00, 32'h0000_0002);
        for (n = 0; out_freq !== 16'd16; n++) tick(n);
        check(brake_active, 32'h0);
        for (n = 0; brake_active !== 1'b1; n++) tick(n);
        check(brake_current, 32'd100);
        check(out_freq <= 16'd15, 32'h1);
        for (n = 0; brake_active === 1'b1; n++) tick(n);
        check(n > 9 && n < 22, 32'h1);
        // zero braking duration so no dc braking, stop by the reference dropping below stop
        bus(1'b1, 6'h0c, 32'h0032_000f);
        bus(1'b1, 6'h00, 32'h0000_0003);
        for (n = 0; out_freq !== tgt; n++) tick(n);
        ref_adc_in <= 12'sd5;
        hit = 1'b0;
        k = 0;
        for (n = 0; out_enable === 1'b1; n++) begin
            tick(n);
            k += (out_freq === 16'd10) ? 1 : 0;
            hit |= brake_active;
        end
        check(hit, 32'h0);
        check(k > 0 && k < 13, 32'h1);
        check(out_freq, 32'h0);
        // start below stop: no output until the reference passes stop
        bus(1'b1, 6'h04, 32'h0000_0008);
        ref_adc_in <= 12'sd9;
        repeat (50) @(posedge clk);
        check(out_enable, 32'h0);
        ref_adc_in <= 12'sd12;
        for (n = 0; out_enable !== 1'b1; n++) tick(n);
        check(out_freq, 32'd8);
        bus(1'b1, 6'h00, 32'h0000_0002);
        for (n = 0; out_enable === 1'b1; n++) tick(n);
        // reversed reference with the pulse monitor selected
        ref_adc_in <= -12'(tgt);
        bus(1'b1, 6'h00, 32'h0000_0023);
        for (n = 0; out_freq !== tgt; n++) tick(n);
        check(out_dir, 32'h1);
        for (n = 0; monitor_pulse !== 1'b1; n++) tick(n);
        check(monitor_dc, 32'h0);
        bus(1'b1, 6'h00, 32'h0000_0000);
        for (n = 0; out_enable === 1'b1; n++) tick(n);
        // external enable while stopped: slow rise, no timer
        bus(1'b1, 6'h0c, 32'h0003_000f);
        ext_brake_enable <= 1'b1;
        for (n = 0; brake_active !== 1'b1; n++) tick(n);
        check(brake_current < 8'd3, 32'h1);
        repeat (4000) @(posedge clk);
        check(brake_current, 32'd3);
        check(brake_active, 32'h1);
        ext_brake_enable <= 1'b0;
        for (n = 0; brake_active === 1'b1; n++) tick(n);
        // carrier clamp and tone gate at the limit and at random
        for (int i = 0; i < 6; i++) begin
            cs = (i < 2) ? 16'h02bc + 16'(i) : 16'(rnd() & 32'h1fff);
            ce = cs < 16'h004b ? 16'h004b : cs > 16'h05dc ? 16'h05dc : cs;
            bus(1'b1, 6'h10, {16'h0005, cs});
            repeat (3) @(posedge clk);
            check(carrier_eff, ce);
            check(tone_level, ce <= 16'h02bc ? 8'h05 : 8'h00);
        end
        complete_run();
    end
endmodule
